// ### rtl/bwa_consts.vh
// Constants for the 7:1 bit and word aligner
`ifndef BWA_CONSTS_VH
`define BWA_CONSTS_VH

// ----------------------------------------
// Phase sweep
// ----------------------------------------
`define BWA_NUM_PHASES      16
`define BWA_PHASE_W         4
`define BWA_PHASES_PER_UI   8
`define BWA_MIN_WINDOW      5'h03
`define BWA_WIN_W           5

// ----------------------------------------
// Word search
// ----------------------------------------
`define BWA_WORD_W          7
`define BWA_CLOCK_PATTERN   7'h63
`define BWA_MAX_ROTATIONS   4'h7

// ----------------------------------------
// Timing
// ----------------------------------------
`define BWA_SETTLE_CYCLES   4'h8
`define BWA_SAMPLE_CYCLES   4'h8
`define BWA_PHASE_DIR_FWD   1'b0

`endif

// ### rtl/bwa_window_finder.v
// Finds the widest circular run of clean phases and its centre
`timescale 1ns/1ps
`include "bwa_consts.vh"

module bwa_window_finder (
  input  wire [15:0] CLEAN_IN,      // One bit per phase, 1 = no transition seen
  output reg  [4:0]  BEST_WIDTH_OUT, // Width of widest clean run
  output reg  [3:0]  BEST_CENTER_OUT // Phase at the middle of that run
);

  integer start;
  integer len;
  reg     [4:0] run;
  reg     [3:0] idx;
  reg           stop;

  // Circular scan from every start phase; combinational, sixteen phases only
  always @* begin
    BEST_WIDTH_OUT  = 5'h00;
    BEST_CENTER_OUT = 4'h0;
    run             = 5'h00;
    stop            = 1'b0;
    idx             = 4'h0;
    for (start = 0; start < `BWA_NUM_PHASES; start = start + 1) begin
      run  = 5'h00;
      stop = 1'b0;
      for (len = 0; len < `BWA_NUM_PHASES; len = len + 1) begin
        idx = start[3:0] + len[3:0];
        if (!stop && CLEAN_IN[idx]) begin
          run = run + 5'h01;
        end else begin
          stop = 1'b1;
        end
      end
      if (run > BEST_WIDTH_OUT) begin
        BEST_WIDTH_OUT  = run;
        BEST_CENTER_OUT = start[3:0] + run[4:1];
      end
    end
  end

endmodule

// ### rtl/bwa_bit_word_aligner.v
// Bit and word aligner for a 7:1 source-synchronous receiver
`timescale 1ns/1ps
`include "bwa_consts.vh"

module bwa_bit_word_aligner (
  input  wire       CLK_IN,          // Divided receive clock, 40 MHz
  input  wire       RESET_N_IN,      // Synchronous reset, active low
  input  wire       PLL_LOCK_IN,     // PLL lock, asynchronous level
  input  wire       UPDATE_IN,       // Start or restart alignment, async level
  input  wire [6:0] CLOCK_LANE_WORD_IN, // Parallel word of clock-lane deserializer
  output reg        PHASE_STEP_PULSE_OUT, // One-cycle PLL phase-step request
  output wire       PHASE_DIRECTION_OUT,  // PLL phase direction, always forward
  output reg        WORD_ROTATE_OUT,      // One-cycle word-rotate pulse
  output reg  [4:0] WINDOW_SIZE_OUT,      // Final clean window width in phases
  output reg        BIT_LOCK_OUT,         // Bit alignment achieved
  output reg        WORD_LOCK_OUT,        // Word alignment achieved
  output reg        READY_OUT             // Whole alignment finished
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam [8:0] ST_IDLE    = 9'h001;
  localparam [8:0] ST_SETTLE  = 9'h002;
  localparam [8:0] ST_SAMPLE  = 9'h004;
  localparam [8:0] ST_STEP    = 9'h008;
  localparam [8:0] ST_GOTO    = 9'h010;
  localparam [8:0] ST_WSETTLE = 9'h020;
  localparam [8:0] ST_WCHECK  = 9'h040;
  localparam [8:0] ST_DONE    = 9'h080;
  localparam [8:0] ST_FAIL    = 9'h100;

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  reg        lock_meta;
  reg        lock_sync;
  reg        upd_meta;
  reg        upd_sync;
  reg        upd_prev;
  reg  [6:0] word_meta;
  reg  [6:0] word_sync;
  reg  [6:0] word_prev;

  always @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      lock_meta <= 1'b0;
      lock_sync <= 1'b0;
      upd_meta  <= 1'b0;
      upd_sync  <= 1'b0;
      upd_prev  <= 1'b0;
      word_meta <= 7'h00;
      word_sync <= 7'h00;
      word_prev <= 7'h00;
    end else begin
      lock_meta <= PLL_LOCK_IN;
      lock_sync <= lock_meta;
      upd_meta  <= UPDATE_IN;
      upd_sync  <= upd_meta;
      upd_prev  <= upd_sync;
      word_meta <= CLOCK_LANE_WORD_IN;
      word_sync <= word_meta;
      word_prev <= word_sync;
    end
  end

  wire update_rise = upd_sync & ~upd_prev;

  // ----------------------------------------
  // Transition detection
  // ----------------------------------------
  // Clock word holds four ones and three zeros; a stable sample point sees the
  // same word every cycle, a point near an edge sees it change
  function word_unstable;
    input [6:0] cur;
    input [6:0] prev;
    begin
      word_unstable = (cur != prev);
    end
  endfunction

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Wait counters run down to zero before the next action
  function wait_over;
    input [3:0] cnt;
    begin
      wait_over = (cnt == 4'h0);
    end
  endfunction

  function [3:0] count_down;
    input [3:0] cnt;
    begin
      count_down = cnt - 4'h1;
    end
  endfunction

  // Phase index wraps after sixteen steps, as the PLL does
  function [3:0] next_phase;
    input [3:0] ph;
    begin
      next_phase = ph + 4'h1;
    end
  endfunction

  function phase_reached;
    input [3:0] ph;
    input [3:0] tgt;
    begin
      phase_reached = (ph == tgt);
    end
  endfunction

  // Width is counted in eighth-UI sample points
  function window_ok;
    input [4:0] width;
    begin
      window_ok = (width >= `BWA_MIN_WINDOW);
    end
  endfunction

  function pattern_seen;
    input [6:0] w;
    begin
      pattern_seen = (w == `BWA_CLOCK_PATTERN);
    end
  endfunction

  // Seven rotations bring the word back to where it started
  function rotations_spent;
    input [3:0] n;
    begin
      rotations_spent = (n == `BWA_MAX_ROTATIONS);
    end
  endfunction

  // True on the sixteenth step of the sweep
  function sweep_last;
    input [4:0] n;
    begin
      sweep_last = (n == 5'h0F);
    end
  endfunction

  // A phase is clean only if no change was seen in its whole sample window
  function clean_bit;
    input       dirty;
    input [6:0] cur;
    input [6:0] prev;
    begin
      clean_bit = ~(dirty | word_unstable(cur, prev));
    end
  endfunction

  // ----------------------------------------
  // Window search
  // ----------------------------------------
  reg  [15:0] clean;
  wire [4:0]  best_width;
  wire [3:0]  best_center;

  bwa_window_finder u_finder (
    .CLEAN_IN        (clean),
    .BEST_WIDTH_OUT  (best_width),
    .BEST_CENTER_OUT (best_center)
  );

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  reg [8:0] state;
  reg [3:0] wait_cnt;
  reg [3:0] phase;
  reg [4:0] steps_done;
  reg [3:0] target;
  reg [3:0] rotations;
  reg       phase_dirty;

  assign PHASE_DIRECTION_OUT = `BWA_PHASE_DIR_FWD;

  always @(posedge CLK_IN) begin
    if (!RESET_N_IN) begin
      state                <= ST_IDLE;
      wait_cnt             <= 4'h0;
      phase                <= 4'h0;
      steps_done           <= 5'h00;
      target               <= 4'h0;
      rotations            <= 4'h0;
      phase_dirty          <= 1'b0;
      clean                <= 16'h0000;
      PHASE_STEP_PULSE_OUT <= 1'b0;
      WORD_ROTATE_OUT      <= 1'b0;
      WINDOW_SIZE_OUT      <= 5'h00;
      BIT_LOCK_OUT         <= 1'b0;
      WORD_LOCK_OUT        <= 1'b0;
      READY_OUT            <= 1'b0;
    end else begin
      PHASE_STEP_PULSE_OUT <= 1'b0;
      WORD_ROTATE_OUT      <= 1'b0;
      if (!lock_sync) begin
        // Losing PLL lock drops bit lock, word lock and ready, keeps the window size, and waits again
        state         <= ST_IDLE;
        BIT_LOCK_OUT  <= 1'b0;
        WORD_LOCK_OUT <= 1'b0;
        READY_OUT     <= 1'b0;
      end else if (update_rise) begin
        state           <= ST_SETTLE;
        wait_cnt        <= `BWA_SETTLE_CYCLES;
        steps_done      <= 5'h00;
        rotations       <= 4'h0;
        clean           <= 16'h0000;
        phase_dirty     <= 1'b0;
        WINDOW_SIZE_OUT <= 5'h00;
        BIT_LOCK_OUT    <= 1'b0;
        WORD_LOCK_OUT   <= 1'b0;
        READY_OUT       <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            // Held until update is seen with PLL locked
            state <= ST_IDLE;
          end
          ST_SETTLE: begin
            // New phase must pass the synchronisers before sampling starts
            if (wait_over(wait_cnt)) begin
              state       <= ST_SAMPLE;
              wait_cnt    <= `BWA_SAMPLE_CYCLES;
              phase_dirty <= 1'b0;
            end else begin
              wait_cnt <= count_down(wait_cnt);
            end
          end
          ST_SAMPLE: begin
            // Word sampled by the phase-shifted fast clock at this trial phase
            if (word_unstable(word_sync, word_prev)) begin
              phase_dirty <= 1'b1;
            end
            if (wait_over(wait_cnt)) begin
              clean[phase] <= clean_bit(phase_dirty, word_sync, word_prev);
              state        <= ST_STEP;
            end else begin
              wait_cnt <= count_down(wait_cnt);
            end
          end
          ST_STEP: begin
            // Sixteen steps bring the PLL back to the first phase
            PHASE_STEP_PULSE_OUT <= 1'b1;
            phase                <= next_phase(phase);
            steps_done           <= steps_done + 5'h01;
            wait_cnt             <= `BWA_SETTLE_CYCLES;
            if (sweep_last(steps_done)) begin
              // Width counted in eighth-UI sample points
              if (window_ok(best_width)) begin
                target          <= best_center;
                WINDOW_SIZE_OUT <= best_width;
                state           <= ST_GOTO;
              end else begin
                state <= ST_FAIL;
              end
            end else begin
              state <= ST_SETTLE;
            end
          end
          ST_GOTO: begin
            // Walk forward only until the chosen phase is reached
            if (!wait_over(wait_cnt)) begin
              wait_cnt <= count_down(wait_cnt);
            end else if (!phase_reached(phase, target)) begin
              PHASE_STEP_PULSE_OUT <= 1'b1;
              phase                <= next_phase(phase);
              wait_cnt             <= `BWA_SETTLE_CYCLES;
            end else begin
              BIT_LOCK_OUT <= 1'b1;
              state        <= ST_WSETTLE;
              wait_cnt     <= `BWA_SETTLE_CYCLES;
            end
          end
          ST_WSETTLE: begin
            // Rotated word must pass the synchronisers before it is judged
            if (wait_over(wait_cnt)) begin
              state <= ST_WCHECK;
            end else begin
              wait_cnt <= count_down(wait_cnt);
            end
          end
          ST_WCHECK: begin
            // Match is checked before the rotation limit so the last try counts
            if (pattern_seen(word_sync)) begin
              WORD_LOCK_OUT <= 1'b1;
              READY_OUT     <= 1'b1;
              state         <= ST_DONE;
            end else if (rotations_spent(rotations)) begin
              state <= ST_FAIL;
            end else begin
              // Deserializer shifts its word by two bits per pulse
              WORD_ROTATE_OUT <= 1'b1;
              rotations       <= rotations + 4'h1;
              wait_cnt        <= `BWA_SETTLE_CYCLES;
              state           <= ST_WSETTLE;
            end
          end
          ST_DONE: begin
            // Parked with status high until update, lock loss or reset
            state <= ST_DONE;
          end
          ST_FAIL: begin
            // Parked with status low until update, lock loss or reset
            BIT_LOCK_OUT  <= 1'b0;
            WORD_LOCK_OUT <= 1'b0;
            READY_OUT     <= 1'b0;
            state         <= ST_FAIL;
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule

// ### tb/bwa_checker_sva.sv
// Assertion checker for the bit and word aligner
`timescale 1ns/1ps
`include "bwa_consts.vh"
module bwa_checker (
  input wire       CLK_IN,               // Clock
  input wire       RESET_N_IN,           // Reset, active low
  input wire       PLL_LOCK_IN,          // PLL lock
  input wire       UPDATE_IN,            // Restart request
  input wire [6:0] CLOCK_LANE_WORD_IN,   // Clock-lane word
  input wire       PHASE_STEP_PULSE_OUT, // Phase step
  input wire       PHASE_DIRECTION_OUT,  // Phase direction
  input wire       WORD_ROTATE_OUT,      // Word rotate
  input wire [4:0] WINDOW_SIZE_OUT,      // Window width
  input wire       BIT_LOCK_OUT,         // Bit lock
  input wire       WORD_LOCK_OUT,        // Word lock
  input wire       READY_OUT             // Ready
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RESET_N_IN);
  rst_outs_a: assert property (disable iff (1'b0) $past(!RESET_N_IN) |->
    !(PHASE_STEP_PULSE_OUT | WORD_ROTATE_OUT | BIT_LOCK_OUT | WORD_LOCK_OUT | READY_OUT) && WINDOW_SIZE_OUT == 5'h00)
    else $error("outputs not cleared by reset");
  dir_fwd_a: assert property (PHASE_DIRECTION_OUT == `BWA_PHASE_DIR_FWD)
    else $error("phase direction not forward");
  step_gap_a: assert property (PHASE_STEP_PULSE_OUT |=> !PHASE_STEP_PULSE_OUT [*8])
    else $error("phase steps too close");
  rot_gap_a: assert property (WORD_ROTATE_OUT |=> !WORD_ROTATE_OUT [*8])
    else $error("word rotations too close");
  lock_gate_a: assert property (!PLL_LOCK_IN [*6] |-> !PHASE_STEP_PULSE_OUT)
    else $error("phase step without PLL lock");
  rot_order_a: assert property (WORD_ROTATE_OUT |-> BIT_LOCK_OUT && !WORD_LOCK_OUT)
    else $error("rotate outside word search");
  ready_done_a: assert property (READY_OUT |-> BIT_LOCK_OUT && WORD_LOCK_OUT)
    else $error("ready before alignment done");
  word_match_a: assert property ($rose(WORD_LOCK_OUT) |-> READY_OUT &&
    $past(CLOCK_LANE_WORD_IN, 4) == `BWA_CLOCK_PATTERN) else $error("word lock on wrong pattern");
  win_min_a: assert property ($rose(BIT_LOCK_OUT) |-> WINDOW_SIZE_OUT >= `BWA_MIN_WINDOW)
    else $error("bit lock on narrow window");
  step_stop_a: assert property (BIT_LOCK_OUT |-> !PHASE_STEP_PULSE_OUT)
    else $error("phase step after bit lock");
endmodule
bind bwa_bit_word_aligner bwa_checker u_chk (.CLK_IN(CLK_IN), .RESET_N_IN(RESET_N_IN), .PLL_LOCK_IN(PLL_LOCK_IN),
  .UPDATE_IN(UPDATE_IN), .CLOCK_LANE_WORD_IN(CLOCK_LANE_WORD_IN), .PHASE_STEP_PULSE_OUT(PHASE_STEP_PULSE_OUT),
  .PHASE_DIRECTION_OUT(PHASE_DIRECTION_OUT), .WORD_ROTATE_OUT(WORD_ROTATE_OUT), .WINDOW_SIZE_OUT(WINDOW_SIZE_OUT),
  .BIT_LOCK_OUT(BIT_LOCK_OUT), .WORD_LOCK_OUT(WORD_LOCK_OUT), .READY_OUT(READY_OUT));

// ### tb/bwa_link_model.sv
// Model of the PLL phase-shift port and the clock-lane deserializer
`timescale 1ns/1ps
module bwa_link_model (
  input  wire        clk_in,      // Divided clock
  input  wire        link_clk_in, // Receive clock lane
  input  wire        step_in,     // Phase step request
  input  wire        rotate_in,   // Word rotate request
  input  wire [15:0] noisy_in,    // 1 = phase sits on a lane edge
  input  wire [2:0]  start_in,    // Initial word offset
  input  wire        bad_in,      // Lane carries a non-clock pattern
  output reg  [3:0]  phase_out,   // Current PLL phase
  output reg  [2:0]  rot_out,     // Rotations taken, mod 7
  output wire [6:0]  word_out     // Parallel clock-lane word
);
  reg         flip = 1'b0;
  wire [6:0]  base = bad_in ? 7'h55 : 7'h63;
  wire [4:0]  sum = rot_out + start_in;
  wire [2:0]  sh = (sum * 5'h02) % 5'h07;
  wire [13:0] dbl = {base, base} << sh;
  // Near an edge the sampled word flips on every lane edge
  assign word_out = (noisy_in[phase_out] && flip) ? ~dbl[13:7] : dbl[13:7];
  initial begin
    phase_out = 4'h0;
    rot_out = 3'h0;
  end
  always @(link_clk_in) flip <= ~flip;
  always @(posedge clk_in) begin
    if (step_in) phase_out <= phase_out + 4'h1;
    if (rotate_in) rot_out <= (rot_out == 3'h6) ? 3'h0 : rot_out + 3'h1;
  end
endmodule

// ### tb/tb.sv
// Self-checking testbench for the bit and word aligner
`timescale 1ns/1ps
module tb;
  reg         clk = 1'b0, rst_n = 1'b0, lock = 1'b0, upd = 1'b0, lclk = 1'b0, bad = 1'b0;
  reg  [15:0] mask = 16'h0000;
  reg  [2:0]  srot = 3'h0;
  wire [6:0]  word;
  wire [4:0]  win;
  wire [3:0]  ph;
  wire [2:0]  rp;
  wire        step, dir, rot, bl, wl, rdy;
  integer     failures = 0, samples_checked = 0, nstep = 0, nrot = 0, s0, r0, kr, p0;
  always #12.5 clk = ~clk;
  always #100 lclk = ~lclk;
  always @(posedge clk) begin
    nstep <= nstep + step;
    nrot <= nrot + rot;
  end
  bwa_bit_word_aligner u_dut (.CLK_IN(clk), .RESET_N_IN(rst_n), .PLL_LOCK_IN(lock), .UPDATE_IN(upd),
    .CLOCK_LANE_WORD_IN(word), .PHASE_STEP_PULSE_OUT(step), .PHASE_DIRECTION_OUT(dir), .WORD_ROTATE_OUT(rot),
    .WINDOW_SIZE_OUT(win), .BIT_LOCK_OUT(bl), .WORD_LOCK_OUT(wl), .READY_OUT(rdy));
  bwa_link_model u_link (.clk_in(clk), .link_clk_in(lclk), .step_in(step), .rotate_in(rot), .noisy_in(mask),
    .start_in(srot), .bad_in(bad), .phase_out(ph), .rot_out(rp), .word_out(word));
  task check(input string name, input [15:0] seen, input [15:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp) begin
      failures = failures + 1;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task summarize;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Kind 0 waits for ready, 1 for a step count, 2 for a rotation count
  task wait_ev(input integer kind, input integer target);
    integer n;
    n = 0;
    while (((kind == 0) ? (rdy !== 1'b1) : (kind == 1) ? (nstep - s0 < target) : (nrot - r0 < target))
           && n < 3000) begin
      @(posedge clk);
      n = n + 1;
    end
    if (n >= 3000) begin
      check("wait timeout", 16'h0001, 16'h0000);
      summarize;
    end
  endtask
  task start_run(input [15:0] m, input [2:0] sr, input b);
    @(posedge clk);
    mask <= m;
    srot <= sr;
    bad <= b;
    upd <= 1'b1;
    s0 = nstep;
    r0 = nrot;
    p0 = ph;
    kr = (14 - rp - sr) % 7;
    repeat (6) @(posedge clk);
    upd <= 1'b0;
  endtask
  task run_good(input [15:0] m, input [2:0] sr, input [4:0] w, input [3:0] c);
    start_run(m, sr, 1'b0);
    check("ready cleared", rdy, 16'h0000);
    wait_ev(0, 0);
    check("window", win, w);
    check("phase", ph, c);
    check("steps", nstep - s0, 16 + ((c - p0) & 15));
    check("rotations", nrot - r0, kr);
    check("word", word, 16'h0063);
    check("locks", {bl, wl, rdy}, 16'h0007);
  endtask
  task run_narrow;
    start_run(16'h9249, 3'h0, 1'b0);
    wait_ev(1, 16);
    repeat (100) @(posedge clk);
    check("narrow steps", nstep - s0, 16'h0010);
    check("narrow locks", {bl, wl, rdy}, 16'h0000);
  endtask
  task run_badword;
    start_run(16'h0F01, 3'h1, 1'b1);
    wait_ev(2, 7);
    repeat (40) @(posedge clk);
    check("bad rotations", nrot - r0, 16'h0007);
    check("bad locks", {bl, wl, rdy}, 16'h0000);
  endtask
  initial begin
    repeat (10) @(posedge clk);
    check("reset outs", {step, rot, win, bl, wl, rdy, dir}, 16'h0000);
    rst_n <= 1'b1;
    start_run(16'h0F01, 3'h3, 1'b0);
    repeat (300) @(posedge clk);
    check("no lock steps", nstep - s0, 16'h0000);
    lock <= 1'b1;
    repeat (5) @(posedge clk);
    run_good(16'h0F01, 3'h3, 5'h07, 4'h4);
    run_good(16'hFFF1, 3'h0, 5'h03, 4'h2);
    run_narrow;
    run_badword;
    summarize;
  end
endmodule
